// *** design/gmdu_pkg.sv ***
// package for the generic message and doorbell unit: offsets, reset values, carriers
// assumes both register ports are simple one-cycle word strobes on the host clock
// Operation
// - processor outbound message write latches, interrupts PCI
// - outbound message write sets its status bit
// - writing one clears status bit, interrupt
// - message mask bit suppresses PCI interrupt
// - processor doorbell set interrupts PCI unless masked
// - PCI write one clears outbound doorbell
// - doorbell mask zero enables, one masks
// - PCI inbound message write interrupts processor
// - processor reads both inbound message words
// - PCI write one sets inbound doorbell
// - messages, status, outbound doorbells reset zero
package gmdu_pkg;
    localparam logic [11:0] OFF_OUT_MSG0   = 12'h100; // outbound message word 0
    localparam logic [11:0] OFF_OUT_MSG1   = 12'h104; // outbound message word 1
    localparam logic [11:0] OFF_OUT_BELL   = 12'h108; // outbound doorbell bits
    localparam logic [11:0] OFF_IN_MSG0    = 12'h110; // inbound message word 0
    localparam logic [11:0] OFF_IN_MSG1    = 12'h114; // inbound message word 1
    localparam logic [11:0] OFF_IN_BELL    = 12'h118; // inbound doorbell bits
    localparam logic [11:0] OFF_OUT_STAT   = 12'h120; // outbound message status
    localparam logic [11:0] OFF_OUT_MASK   = 12'h124; // outbound message mask
    localparam logic [11:0] OFF_BELL_MASK  = 12'h128; // outbound doorbell mask
    localparam logic [31:0] RST_WORD       = 32'h0000_0000; // message word and read data reset
    localparam logic [1:0]  RST_MSG_MASK   = 2'h0; // message mask reset
    localparam logic [31:0] RST_BELL_MASK  = 32'h0000_0000; // doorbell mask reset
    localparam logic [31:0] RST_IN_BELL    = 32'h0000_0000; // inbound bell reset
    localparam logic [1:0]  RST_OUT_STAT   = 2'h0; // outbound status reset
    localparam logic        RST_LEVEL      = 1'b0; // pending flag and interrupt reset
    localparam int          BIT_IN_MSG     = 2; // processor-view inbound pending bit
    localparam int          BIT_FLAG0      = 0; // status / mask bit for word 0
    localparam int          BIT_FLAG1      = 1; // status / mask bit for word 1

    // one register access on either side
    typedef struct packed {
        logic        wr;   // write strobe
        logic        rd;   // read strobe
        logic [11:0] addr; // byte offset in the group
        logic [31:0] wdata; // write data
    } gmdu_req_t;
endpackage

// *** design/gmdu_flag32.sv ***
// 32 sticky flags with separate set and clear masks
// assumes set and clear arrive as one-cycle masks on clock_i
`timescale 1ns/1ps
module gmdu_flag32 #(
    parameter int W = 32
) (
    input  wire logic         clock_i, // host clock
    input  wire logic         rstn_i,  // async reset, low
    input  wire logic [W-1:0] set_i,   // bits to set
    input  wire logic [W-1:0] clr_i,   // bits to clear
    output logic      [W-1:0] flag_o   // flag state
);
    // set beats clear in the same cycle
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_o <= '0;
        end else begin
            flag_o <= (flag_o & ~clr_i) | set_i;
        end
    end
endmodule

// *** design/gmdu_top.sv ***
// message and doorbell unit: processor register group and PCI register group
// assumes both request ports are on clock_i; read data is valid the cycle after rd
`timescale 1ns/1ps
module gmdu_top (
    input  wire logic               clock_i,     // host bus clock, 10 MHz
    input  wire logic               rstn_i,      // async reset, low
    input  wire gmdu_pkg::gmdu_req_t cpu_req_i,  // processor side access
    output logic [31:0]             cpu_rdata_o, // processor read data
    input  wire gmdu_pkg::gmdu_req_t pci_req_i,  // PCI side access
    output logic [31:0]             pci_rdata_o, // PCI read data
    input  wire logic               processor_irq_enable_i, // processor irq enable
    output logic                    pci_irq_o,   // PCI interrupt, high active
    output logic                    cpu_irq_o    // processor interrupt, high active
);
    logic [31:0] out_msg0_r;      // outbound message word 0
    logic [31:0] out_msg1_r;      // outbound message word 1
    logic [31:0] in_msg0_r;       // inbound message word 0
    logic [31:0] in_msg1_r;       // inbound message word 1
    logic [1:0]  out_msg_flag_r;  // outbound message status
    logic [1:0]  out_msg_mask_r;  // outbound message mask
    logic [31:0] bell_mask_r;     // outbound doorbell mask
    logic        in_msg_flag_r;   // inbound message pending
    logic [31:0] out_bell_flag;   // outbound doorbells
    logic [31:0] in_bell_flag;    // inbound doorbells
    logic [31:0] ob_set;          // outbound bell set mask
    logic [31:0] ob_clr;          // outbound bell clear mask
    logic [31:0] ib_set;          // inbound bell set mask
    logic [31:0] ib_clr;          // inbound bell clear mask
    logic        cw0, cw1, pw0, pw1; // message word write strobes

    // write hit on a given offset
    function automatic logic hit(input gmdu_pkg::gmdu_req_t r, input logic [11:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    assign cw0 = hit(cpu_req_i, gmdu_pkg::OFF_OUT_MSG0);
    assign cw1 = hit(cpu_req_i, gmdu_pkg::OFF_OUT_MSG1);
    assign pw0 = hit(pci_req_i, gmdu_pkg::OFF_IN_MSG0);
    assign pw1 = hit(pci_req_i, gmdu_pkg::OFF_IN_MSG1);

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_msg0_r <= gmdu_pkg::RST_WORD;
            out_msg1_r <= gmdu_pkg::RST_WORD;
        end else begin
            if (cw0) begin
                out_msg0_r <= cpu_req_i.wdata;
            end
            if (cw1) begin
                out_msg1_r <= cpu_req_i.wdata;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            in_msg0_r <= gmdu_pkg::RST_WORD;
            in_msg1_r <= gmdu_pkg::RST_WORD;
        end else begin
            if (pw0) begin
                in_msg0_r <= pci_req_i.wdata;
            end
            if (pw1) begin
                in_msg1_r <= pci_req_i.wdata;
            end
        end
    end

    // inbound message pending: set by PCI write, cleared by processor w1c at its status slot
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            in_msg_flag_r <= gmdu_pkg::RST_LEVEL;
        end else if (pw0 || pw1) begin
            in_msg_flag_r <= 1'b1;
        end else if (hit(cpu_req_i, gmdu_pkg::OFF_OUT_STAT) &&
                     cpu_req_i.wdata[gmdu_pkg::BIT_IN_MSG]) begin
            in_msg_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_msg_flag_r <= gmdu_pkg::RST_OUT_STAT;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0) ? cw0 : cw1) begin
                    out_msg_flag_r[i] <= 1'b1;
                end else if (hit(pci_req_i, gmdu_pkg::OFF_OUT_STAT) && pci_req_i.wdata[i]) begin
                    out_msg_flag_r[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_msg_mask_r <= gmdu_pkg::RST_MSG_MASK;
            bell_mask_r    <= gmdu_pkg::RST_BELL_MASK;
        end else begin
            if (hit(pci_req_i, gmdu_pkg::OFF_OUT_MASK)) begin
                out_msg_mask_r <= pci_req_i.wdata[1:0];
            end
            if (hit(pci_req_i, gmdu_pkg::OFF_BELL_MASK)) begin
                bell_mask_r <= pci_req_i.wdata;
            end
        end
    end

    assign ob_set = hit(cpu_req_i, gmdu_pkg::OFF_OUT_BELL) ? cpu_req_i.wdata : 32'h0000_0000;
    assign ob_clr = hit(pci_req_i, gmdu_pkg::OFF_OUT_BELL) ? pci_req_i.wdata : 32'h0000_0000;
    assign ib_set = hit(pci_req_i, gmdu_pkg::OFF_IN_BELL) ? pci_req_i.wdata : 32'h0000_0000;
    // processor clears inbound doorbells by writing ones
    assign ib_clr = hit(cpu_req_i, gmdu_pkg::OFF_IN_BELL) ? cpu_req_i.wdata : 32'h0000_0000;

    // outbound doorbell flags
    gmdu_flag32 #(.W(32)) u_out_bell (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .set_i   (ob_set),
        .clr_i   (ob_clr),
        .flag_o  (out_bell_flag)
    );

    // inbound doorbell flags
    gmdu_flag32 #(.W(32)) u_in_bell (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .set_i   (ib_set),
        .clr_i   (ib_clr),
        .flag_o  (in_bell_flag)
    );

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pci_irq_o <= gmdu_pkg::RST_LEVEL;
        end else begin
            pci_irq_o <= (|(out_msg_flag_r & ~out_msg_mask_r)) |
                         (|(out_bell_flag & ~bell_mask_r));
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpu_irq_o <= gmdu_pkg::RST_LEVEL;
        end else begin
            cpu_irq_o <= processor_irq_enable_i & ((|in_bell_flag) | in_msg_flag_r);
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpu_rdata_o <= gmdu_pkg::RST_WORD;
        end else if (cpu_req_i.rd) begin
            if (cpu_req_i.addr == gmdu_pkg::OFF_OUT_MSG0) begin
                cpu_rdata_o <= out_msg0_r;
            end else if (cpu_req_i.addr == gmdu_pkg::OFF_OUT_MSG1) begin
                cpu_rdata_o <= out_msg1_r;
            end else if (cpu_req_i.addr == gmdu_pkg::OFF_OUT_BELL) begin
                cpu_rdata_o <= out_bell_flag;
            end else if (cpu_req_i.addr == gmdu_pkg::OFF_IN_MSG0) begin
                cpu_rdata_o <= in_msg0_r;
            end else if (cpu_req_i.addr == gmdu_pkg::OFF_IN_MSG1) begin
                cpu_rdata_o <= in_msg1_r;
            end else if (cpu_req_i.addr == gmdu_pkg::OFF_IN_BELL) begin
                cpu_rdata_o <= in_bell_flag;
            end else if (cpu_req_i.addr == gmdu_pkg::OFF_OUT_STAT) begin
                cpu_rdata_o <= {29'h0, in_msg_flag_r, out_msg_flag_r};
            end else begin
                cpu_rdata_o <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pci_rdata_o <= gmdu_pkg::RST_WORD;
        end else if (pci_req_i.rd) begin
            if (pci_req_i.addr == gmdu_pkg::OFF_OUT_MSG0) begin
                pci_rdata_o <= out_msg0_r;
            end else if (pci_req_i.addr == gmdu_pkg::OFF_OUT_MSG1) begin
                pci_rdata_o <= out_msg1_r;
            end else if (pci_req_i.addr == gmdu_pkg::OFF_OUT_BELL) begin
                pci_rdata_o <= out_bell_flag;
            end else if (pci_req_i.addr == gmdu_pkg::OFF_IN_MSG0) begin
                pci_rdata_o <= in_msg0_r;
            end else if (pci_req_i.addr == gmdu_pkg::OFF_IN_MSG1) begin
                pci_rdata_o <= in_msg1_r;
            end else if (pci_req_i.addr == gmdu_pkg::OFF_IN_BELL) begin
                pci_rdata_o <= in_bell_flag;
            end else if (pci_req_i.addr == gmdu_pkg::OFF_OUT_STAT) begin
                pci_rdata_o <= {30'h0, out_msg_flag_r};
            end else if (pci_req_i.addr == gmdu_pkg::OFF_OUT_MASK) begin
                pci_rdata_o <= {30'h0, out_msg_mask_r};
            end else if (pci_req_i.addr == gmdu_pkg::OFF_BELL_MASK) begin
                pci_rdata_o <= bell_mask_r;
            end else begin
                pci_rdata_o <= 32'h0000_0000;
            end
        end
    end

    a_msg_latch_raise: assert property (@(posedge clock_i) disable iff (!rstn_i)
        cw0 |=> (out_msg0_r == $past(cpu_req_i.wdata)) && out_msg_flag_r[0])
        else $error("outbound word 0 write not latched");

    a_stat_set_word1: assert property (@(posedge clock_i) disable iff (!rstn_i)
        cw1 |=> out_msg_flag_r[1])
        else $error("status bit 1 not set");

    a_stat_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !cw1 && !(hit(pci_req_i, gmdu_pkg::OFF_OUT_STAT) && pci_req_i.wdata[1])
        |=> $stable(out_msg_flag_r[gmdu_pkg::BIT_FLAG1]))
        else $error("status bit 1 changed without an event");

    a_stat_w1c_clear: assert property (@(posedge clock_i) disable iff (!rstn_i)
        hit(pci_req_i, gmdu_pkg::OFF_OUT_STAT) && pci_req_i.wdata[0] && !cw0
        |=> !out_msg_flag_r[0])
        else $error("status bit 0 not cleared");

    a_mask_blocks_irq: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (out_msg_mask_r == 2'h3) && (out_bell_flag == 32'h0) |=> !pci_irq_o)
        else $error("masked message raised irq");

    // processor rings unmasked doorbell 0
    sequence s_bell_set;
        hit(cpu_req_i, gmdu_pkg::OFF_OUT_BELL) && cpu_req_i.wdata[0] && !bell_mask_r[0];
    endsequence

    a_bell_irq_raise: assert property (@(posedge clock_i) disable iff (!rstn_i)
        s_bell_set ##1 !bell_mask_r[0] |=> pci_irq_o)
        else $error("doorbell did not raise pci irq");

    a_bell_w1c_clear: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ob_clr[3] && !ob_set[3] |=> !out_bell_flag[3])
        else $error("outbound doorbell not cleared");

    a_bell_zero_keep: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !ob_clr[3] && !ob_set[3] |=> $stable(out_bell_flag[3]))
        else $error("outbound doorbell changed without a write");

    a_bell_mask_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
        hit(pci_req_i, gmdu_pkg::OFF_BELL_MASK) |=> (bell_mask_r == $past(pci_req_i.wdata)))
        else $error("doorbell mask write not taken");

    a_in_msg_irq: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (pw0 || pw1) ##1 processor_irq_enable_i |=> cpu_irq_o)
        else $error("inbound message irq missing");

    a_in_word_store: assert property (@(posedge clock_i) disable iff (!rstn_i)
        pw1 |=> (in_msg1_r == $past(pci_req_i.wdata)))
        else $error("inbound word 1 not stored");

    a_cpu_read_in: assert property (@(posedge clock_i) disable iff (!rstn_i)
        cpu_req_i.rd && (cpu_req_i.addr == gmdu_pkg::OFF_IN_MSG0)
        |=> (cpu_rdata_o == $past(in_msg0_r)))
        else $error("processor read of inbound word 0 wrong");

    a_in_bell_set: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ib_set[5] |=> in_bell_flag[5])
        else $error("inbound doorbell not set");

    a_in_bell_keep: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !ib_set[5] && !ib_clr[5] |=> $stable(in_bell_flag[5]))
        else $error("inbound doorbell changed without a write");

    a_pci_irq_raise: assert property (@(posedge clock_i) disable iff (!rstn_i)
        out_msg_flag_r[gmdu_pkg::BIT_FLAG0] && !out_msg_mask_r[gmdu_pkg::BIT_FLAG0]
        |=> pci_irq_o)
        else $error("unmasked message status without pci irq");

    a_pci_irq_drop: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (out_msg_flag_r == 2'h0) && (out_bell_flag == 32'h0) |=> !pci_irq_o)
        else $error("pci irq with nothing pending");

    a_cpu_irq_gate: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !$past(processor_irq_enable_i) |-> !cpu_irq_o)
        else $error("processor irq while disabled");

    a_cpu_irq_bell: assert property (@(posedge clock_i) disable iff (!rstn_i)
        processor_irq_enable_i && (in_bell_flag != 32'h0) |=> cpu_irq_o)
        else $error("inbound doorbell irq missing");
endmodule

// *** sim/gmdu_port_master.sv ***
// bus master model for one register group of the message unit
// assumes requests are taken at a rising edge, read data within one cycle
`timescale 1ns/1ps
module gmdu_port_master (
    input  wire logic                clock_i, // host clock
    output gmdu_pkg::gmdu_req_t      req_o,   // request to the unit
    input  wire logic [31:0]         rdata_i  // read data from the unit
);
    // idle at time zero
    initial req_o = '0;

    // one write, launched on a falling edge, held across one rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clock_i);
        req_o <= '{1'b1, 1'b0, a, d};
        @(negedge clock_i);
        // released lines show junk, not the old value
        req_o <= '{1'b0, 1'b0, ~a, ~d};
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(negedge clock_i);
        req_o <= '{1'b0, 1'b1, a, 32'h0};
        @(negedge clock_i);
        req_o <= '{1'b0, 1'b0, ~a, 32'hffffffff};
        @(negedge clock_i);
        d = rdata_i;
    endtask
endmodule

// *** sim/generic_message_doorbell_unit_bench.sv ***
// self-checking bench for the message and doorbell unit
// assumes two port master models stand in for processor and PCI master
`timescale 1ns/1ps
module generic_message_doorbell_unit_bench;
    logic                clock_i;         // host clock
    logic                rstn_i;          // reset, low
    logic                irq_en;          // processor irq enable
    gmdu_pkg::gmdu_req_t cpu_req;         // processor requests
    gmdu_pkg::gmdu_req_t pci_req;         // PCI requests
    logic [31:0]         cpu_rdata;       // processor read data
    logic [31:0]         pci_rdata;       // PCI read data
    logic                pci_irq;         // PCI interrupt
    logic                cpu_irq;         // processor interrupt
    int                  n_fail;          // mismatches
    int                  samples_checked; // comparisons
    int                  cycles;          // timeout counter
    integer              seed;            // random seed
    logic [31:0]         d, m, b, c;      // scratch values
    logic [11:0]         a;               // scratch offset

    gmdu_top dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .cpu_req_i(cpu_req),
        .cpu_rdata_o(cpu_rdata), .pci_req_i(pci_req), .pci_rdata_o(pci_rdata),
        .processor_irq_enable_i(irq_en), .pci_irq_o(pci_irq), .cpu_irq_o(cpu_irq));
    gmdu_port_master cpu_u (.clock_i(clock_i), .req_o(cpu_req), .rdata_i(cpu_rdata));
    gmdu_port_master pci_u (.clock_i(clock_i), .req_o(pci_req), .rdata_i(pci_rdata));

    // 100 ns clock
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    // hang guard, well above the few hundred cycles needed
    always @(posedge clock_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            close_out();
        end
    end

    // compare a word
    task automatic chk_word(input string w, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", w, e, g);
        end
    endtask

    // compare a single flag
    task automatic chk_bit(input string w, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %b seen %b", w, e, g);
        end
    endtask

    // read on one side (1 = PCI) and compare
    task automatic rd_chk(input bit pci, input logic [11:0] ad, input logic [31:0] e);
        logic [31:0] g;
        if (pci) pci_u.rd(ad, g);
        else cpu_u.rd(ad, g);
        chk_word($sformatf("%s word %h", pci ? "pci" : "cpu", ad), e, g);
    endtask

    // let flag and interrupt updates land
    task automatic settle;
        repeat (3) @(negedge clock_i);
    endtask

    // expected PCI interrupt level
    function automatic logic exp_pci(input logic [1:0] st, input logic [1:0] mk,
                                     input logic [31:0] bl, input logic [31:0] bm);
        return (|(st & ~mk)) | (|(bl & ~bm));
    endfunction

    // counts, verdict, end of run
    task close_out;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // main sequence
    initial begin
        logic [11:0] offs [10];
        offs = '{12'h100, 12'h104, 12'h108, 12'h110, 12'h114, 12'h118,
                 12'h120, 12'h124, 12'h128, 12'h10c};
        seed = 32'h66050dfc;
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        rstn_i = 1'b0;
        irq_en = 1'b0;
        repeat (10) @(negedge clock_i);
        rstn_i = 1'b1;
        // reset values, with one unmapped hole
        for (int i = 0; i < 10; i++) rd_chk(1'b1, offs[i], 32'h0);
        chk_bit("pci irq", 1'b0, pci_irq);
        $display("test reset done");
        // outbound messages with mask clear, then random mask settings
        for (int k = 0; k < 6; k++) begin
            m = (k < 2) ? 32'h0 : 32'($random(seed)) & 32'h3;
            d = $random(seed);
            a = k[0] ? gmdu_pkg::OFF_OUT_MSG1 : gmdu_pkg::OFF_OUT_MSG0;
            pci_u.wr(gmdu_pkg::OFF_OUT_MASK, m);
            cpu_u.wr(a, d);
            settle();
            rd_chk(1'b1, a, d);
            rd_chk(1'b1, gmdu_pkg::OFF_OUT_STAT, 32'(k[0] + 1));
            chk_bit("msg irq", exp_pci(k[0] ? 2'h2 : 2'h1, m[1:0], 32'h0, 32'h0), pci_irq);
            pci_u.wr(gmdu_pkg::OFF_OUT_STAT, 32'h0);
            settle();
            rd_chk(1'b1, gmdu_pkg::OFF_OUT_STAT, 32'(k[0] + 1));
            pci_u.wr(gmdu_pkg::OFF_OUT_STAT, 32'h3);
            settle();
            rd_chk(1'b1, gmdu_pkg::OFF_OUT_STAT, 32'h0);
            chk_bit("msg irq off", 1'b0, pci_irq);
        end
        $display("test outbound message done");
        // outbound doorbells with random masks and partial clears
        for (int k = 0; k < 6; k++) begin
            m = (k == 0) ? 32'h0 : $random(seed);
            b = (k == 5) ? 32'hffffffff : $random(seed);
            c = $random(seed);
            pci_u.wr(gmdu_pkg::OFF_BELL_MASK, m);
            cpu_u.wr(gmdu_pkg::OFF_OUT_BELL, b);
            settle();
            rd_chk(1'b1, gmdu_pkg::OFF_OUT_BELL, b);
            rd_chk(1'b1, gmdu_pkg::OFF_BELL_MASK, m);
            chk_bit("bell irq", exp_pci(2'h0, 2'h0, b, m), pci_irq);
            pci_u.wr(gmdu_pkg::OFF_OUT_BELL, c);
            settle();
            rd_chk(1'b1, gmdu_pkg::OFF_OUT_BELL, b & ~c);
            chk_bit("bell irq part", exp_pci(2'h0, 2'h0, b & ~c, m), pci_irq);
            pci_u.wr(gmdu_pkg::OFF_OUT_BELL, 32'hffffffff);
            settle();
            chk_bit("bell irq off", 1'b0, pci_irq);
        end
        $display("test outbound doorbell done");
        // inbound messages and doorbells, enable on and off
        for (int k = 0; k < 4; k++) begin
            @(negedge clock_i);
            irq_en = k[0];
            d = $random(seed);
            b = 32'($random(seed)) | 32'h1;
            a = k[1] ? gmdu_pkg::OFF_IN_MSG1 : gmdu_pkg::OFF_IN_MSG0;
            pci_u.wr(a, d);
            settle();
            rd_chk(1'b0, a, d);
            chk_bit("in msg irq", irq_en, cpu_irq);
            cpu_u.wr(gmdu_pkg::OFF_OUT_STAT, 32'h4);
            settle();
            chk_bit("in msg irq off", 1'b0, cpu_irq);
            pci_u.wr(gmdu_pkg::OFF_IN_BELL, b);
            pci_u.wr(gmdu_pkg::OFF_IN_BELL, 32'h0);
            settle();
            rd_chk(1'b0, gmdu_pkg::OFF_IN_BELL, b);
            chk_bit("in bell irq", irq_en, cpu_irq);
            cpu_u.wr(gmdu_pkg::OFF_IN_BELL, b);
            settle();
            rd_chk(1'b0, gmdu_pkg::OFF_IN_BELL, 32'h0);
            chk_bit("in bell irq off", 1'b0, cpu_irq);
        end
        $display("test inbound done");
        close_out();
    end
endmodule
